// >>> hw/ldoc_edge_sync.sv
/*
  Rising-edge detector for one level input.
  Assumes: input synchronous to the clock.
*/
`timescale 1ns/1ps
module ldoc_edge_sync (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic level_i,
  output logic rise_o
);

  logic level_q; // Last sampled level

  // Remember previous level, frozen with clock enable
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q <= 1'b0;
    end else if (clk_en_i) begin
      level_q <= level_i;
    end
  end

  assign rise_o = clk_en_i & level_i & ~level_q;

endmodule : ldoc_edge_sync

// >>> hw/ldoc_regs.sv
/*
  Regulator control register bank with start-up and sleep slot decode,
  hardware control selection, undervoltage response and interrupt.
  Assumes: the sequencer reports phase and current timeslot (1 to 5,
  counted up on start-up and down on sleep); inputs are synchronous;
  the regulator holds the voltage table and stretches the reset
  request; the host never raises write and read strobes together.
*/
`timescale 1ns/1ps
`include "ldoc_defines.svh"
module ldoc_regs (
  // Clock, reset and enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Register port
  input wire ldoc_pkg::ldoc_bus_req_type bus_req_i,
  output logic [15:0] rdata_o,
  // Sequencer and pins
  input wire ldoc_pkg::ldoc_seq_type seq_i,
  input wire logic hw_control1_i,
  input wire logic hw_control2_i,
  input wire logic hw_enable1_i,
  input wire logic hw_enable2_i,
  input wire logic undervoltage_i,
  // Towards the regulator and the system
  output ldoc_pkg::ldoc_drive_type drive_o,
  output logic system_reset_req_o,
  output logic irq_o
);
  import ldoc_pkg::*;

  // Stored registers; reserved bits are masked on write so that they
  // always read back as zero and never reach the drive logic
  logic [15:0] general; // Undervoltage, hardware control, float, variant
  logic [15:0] on_ctrl; // ON slot, mode, voltage
  logic [15:0] sleep_ctrl; // SLEEP slot, mode, voltage
  logic [15:0] irq_status; // Sticky event bits
  logic [15:0] irq_mask; // Interrupt enables
  // Event and sequencing state
  logic uv_rise; // New undervoltage event
  logic [15:0] status_clr; // Status bits cleared by this write
  logic [15:0] status_set; // Status bits set by this event
  logic uv_shutdown; // Regulator held off after fault
  logic enabled; // Sequencer-level enable state
  logic in_sleep_cond; // Regulator in its SLEEP condition
  logic hwc_active; // Hardware control in force
  ldoc_drive_type next_drive; // Drive computed this cycle

  // Field views, decoded once so that every process below agrees on
  // the same bit positions; pure wiring with no state of their own
  ldoc_uv_resp_type uv_resp; // Response to a new fault
  logic [1:0] hwc_src; // Which control pins may take over
  logic [1:0] hwc_mode; // Mode while hardware control is in force
  logic [2:0] on_slot; // Start-up timeslot or pin code
  logic [2:0] slp_slot; // Sleep timeslot code
  logic [2:0] slp_target; // Sleep timeslot for this code
  logic slp_disables; // Sleep code disables regulator
  logic hw_assigned; // ON slot hands enable to a pin
  logic hw_en_level; // Selected hardware enable pin

  // Response code read as the enum so the case below stays readable
  assign uv_resp = ldoc_uv_resp_type'(
    general[`LDOC_UV_RESP_HI:`LDOC_UV_RESP_LO]);
  assign hwc_src = general[`LDOC_HWC_SRC_HI:`LDOC_HWC_SRC_LO];
  assign hwc_mode = general[`LDOC_HWC_MODE_HI:`LDOC_HWC_MODE_LO];
  assign on_slot = on_ctrl[`LDOC_SLOT_HI:`LDOC_SLOT_LO];
  assign slp_slot = sleep_ctrl[`LDOC_SLOT_HI:`LDOC_SLOT_LO];

  // Undervoltage edge, only new faults count
  // A fault that stays high raises one event; software clears the
  // status bit and waits for the next rise to see it again
  ldoc_edge_sync u_uv_edge (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .level_i(undervoltage_i),
    .rise_o(uv_rise)
  );

  // Register writes; reserved bits are not stored
  // Unmapped writes are dropped; the status register has its own
  // process below, so a clear never races this one
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Defaults: normal ON mode, low-power SLEEP mode
      general <= `LDOC_GENERAL_RST;
      on_ctrl <= `LDOC_ON_RST;
      sleep_ctrl <= `LDOC_SLEEP_RST;
      irq_mask <= `LDOC_IRQ_MASK_RST;
    end else if (clk_en_i && bus_req_i.wr) begin
      // Address decode, one register per word
      if (bus_req_i.addr == `LDOC_ADDR_GENERAL) begin
        general <= bus_req_i.wdata & `LDOC_GENERAL_MASK;
      end else if (bus_req_i.addr == `LDOC_ADDR_ON) begin
        on_ctrl <= bus_req_i.wdata & `LDOC_STATE_MASK;
      end else if (bus_req_i.addr == `LDOC_ADDR_SLEEP) begin
        sleep_ctrl <= bus_req_i.wdata & `LDOC_STATE_MASK;
      end else if (bus_req_i.addr == `LDOC_ADDR_IRQ_MASK) begin
        irq_mask <= bus_req_i.wdata & `LDOC_IRQ_BITS;
      end
    end
  end

  // Status clear and set terms, one bit per event
  always_comb begin
    status_clr = 16'h0000; // No clear unless status is written
    status_set = 16'h0000; // No event unless an edge arrived
    if (bus_req_i.wr && bus_req_i.addr == `LDOC_ADDR_IRQ_STATUS) begin
      // Write one to clear; only implemented bits respond
      status_clr = bus_req_i.wdata & `LDOC_IRQ_BITS;
    end
    // Interrupt raised whatever the response setting
    status_set[`LDOC_IRQ_UV_BIT] = uv_rise;
    // Reserved response code flagged so software notices
    status_set[`LDOC_IRQ_RSVD_BIT] = uv_rise &&
      uv_resp == LDOC_UV_RESERVED;
  end

  // Sticky status; a new event beats a same-cycle clear, so an
  // event cannot be lost between a status read and its clear
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= 16'h0000;
    end else if (clk_en_i) begin
      irq_status <= (irq_status & ~status_clr) | status_set;
    end
  end

  // Read data, valid the cycle after the strobe only
  // Reads have no side effects; status clears only on a write
  // Returning zero between reads keeps a stale word off the bus
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      if (!bus_req_i.rd) begin
        // Quiet bus between reads
        rdata_o <= 16'h0000;
      end else if (bus_req_i.addr == `LDOC_ADDR_GENERAL) begin
        // Stored values, reserved bits already zero
        rdata_o <= general;
      end else if (bus_req_i.addr == `LDOC_ADDR_ON) begin
        rdata_o <= on_ctrl;
      end else if (bus_req_i.addr == `LDOC_ADDR_SLEEP) begin
        rdata_o <= sleep_ctrl;
      end else if (bus_req_i.addr == `LDOC_ADDR_IRQ_STATUS) begin
        rdata_o <= irq_status;
      end else if (bus_req_i.addr == `LDOC_ADDR_IRQ_MASK) begin
        rdata_o <= irq_mask;
      end else begin
        rdata_o <= 16'h0000; // Unmapped reads as zero
      end
    end
  end

  // Level interrupt from unmasked sticky bits
  // Registered, so the pin moves one cycle after status or mask
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      // Any unmasked sticky bit holds the line high
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // Undervoltage response
  // Only the rising edge acts, so a fault that stays high does not
  // request a reset every cycle. Limitation: a latched shut-down is
  // lifted only by a fresh start-up, not by clearing the status bit
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uv_shutdown <= 1'b0;
      system_reset_req_o <= 1'b0;
    end else if (clk_en_i) begin
      // Pulse falls again unless a new fault arrives
      system_reset_req_o <= 1'b0;
      if (uv_rise) begin
        // Reset request is a one-cycle pulse
        case (uv_resp)
          LDOC_UV_SHUT_REG: uv_shutdown <= 1'b1;
          LDOC_UV_SHUT_SYS: system_reset_req_o <= 1'b1;
          default: ; // Ignore, and reserved treated as ignore
        endcase
      end else if (seq_i.phase == LDOC_PH_STARTUP) begin
        // Fresh start-up releases a faulted regulator
        uv_shutdown <= 1'b0;
      end
    end
  end

  // Pin assignment and hardware control selection
  // Enable pins matter only for ON slot codes 6 and 7. With the
  // either-input source one released pin alone does not end control
  always_comb begin
    // ON slot codes 6 and 7 hand the enable to a pin
    hw_assigned = (on_slot == `LDOC_SLOT_HWE1) ||
      (on_slot == `LDOC_SLOT_HWE2);
    hw_en_level = (on_slot == `LDOC_SLOT_HWE1) ? hw_enable1_i
      : hw_enable2_i;
    // Source picks which control pins may take over
    case (hwc_src)
      2'h1: hwc_active = hw_control1_i;
      2'h2: hwc_active = hw_control2_i;
      2'h3: hwc_active = hw_control1_i | hw_control2_i;
      default: hwc_active = 1'b0;
    endcase
  end

  // Sleep slot decode; timeslots count down during sleep
  // Codes 1 to 5 disable, unless a pin owns the enable; then the same
  // timeslot only moves the regulator to its SLEEP settings
  always_comb begin
    slp_disables = 1'b0;
    case (slp_slot)
      // Transition-only codes keep the regulator on
      3'h0: slp_target = 3'h5;
      3'h6: slp_target = 3'h3;
      3'h7: slp_target = 3'h1;
      default: begin
        // Smaller code acts earlier in the sequence
        // Code 1 acts in timeslot 5, code 5 in timeslot 1
        slp_target = 3'h6 - slp_slot;
        slp_disables = ~hw_assigned;
      end
    endcase
  end

  // Enable and sleep condition tracking across sequencer phases
  // The enable is a level kept between timeslots, since the sequencer
  // passes each timeslot only once; OFF clears all for a clean start
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enabled <= 1'b0;
      in_sleep_cond <= 1'b0;
    end else if (clk_en_i) begin
      case (seq_i.phase)
        LDOC_PH_OFF: begin
          // Powered down: forget enable and sleep condition
          enabled <= 1'b0;
          in_sleep_cond <= 1'b0;
        end
        LDOC_PH_STARTUP: begin
          in_sleep_cond <= 1'b0;
          // Enable exactly in the programmed timeslot
          // Pin-assigned regulators ignore start-up timeslots
          if (on_slot != `LDOC_SLOT_NONE && !hw_assigned &&
              seq_i.slot == on_slot) begin
            enabled <= 1'b1;
          end
        end
        LDOC_PH_SLEEP: begin
          // Act once the count reaches this regulator's timeslot
          if (seq_i.slot == slp_target) begin
            if (slp_disables) begin
              enabled <= 1'b0;
            end else begin
              in_sleep_cond <= 1'b1;
            end
          end
        end
        // Enable kept as it is while running
        default: in_sleep_cond <= 1'b0; // ON phase
      endcase
    end
  end

  // Output drive selection; the voltage table lives in the regulator,
  // codes 00h-0Eh 50mV steps and 0Fh-1Fh 100mV steps pass unchanged
  // Priority, highest first: fault shut-down, SLEEP condition,
  // hardware control, then the plain ON settings
  always_comb begin
    logic mode_lp;
    logic on_now;
    mode_lp = 1'b0;
    on_now = 1'b0;
    next_drive.vcode = on_ctrl[`LDOC_VCODE_HI:`LDOC_VCODE_LO];
    mode_lp = on_ctrl[`LDOC_MODE_BIT];
    // Pin ownership decides where the enable comes from
    if (hw_assigned) begin
      on_now = hw_en_level;
    end else begin
      on_now = enabled;
    end
    // SLEEP condition wins over hardware control
    if (in_sleep_cond) begin
      next_drive.vcode =
        sleep_ctrl[`LDOC_VCODE_HI:`LDOC_VCODE_LO];
      mode_lp = sleep_ctrl[`LDOC_MODE_BIT];
    end else if (hwc_active) begin
      if (general[`LDOC_HWC_VCH_BIT]) begin
        next_drive.vcode =
          sleep_ctrl[`LDOC_VCODE_HI:`LDOC_VCODE_LO];
      end
      // Mode code 01 turns the regulator off
      case (hwc_mode)
        2'h1: on_now = 1'b0;
        2'h3: mode_lp = on_ctrl[`LDOC_MODE_BIT];
        default: mode_lp = 1'b1;
      endcase
    end
    // A fault shut-down overrides every other source
    if (uv_shutdown) begin
      on_now = 1'b0;
    end
    // Discharge only while off, never fighting the pass device
    next_drive.enable = on_now;
    next_drive.low_power = mode_lp;
    next_drive.lp_20ma = general[`LDOC_LPV_BIT];
    next_drive.discharge = ~on_now & ~general[`LDOC_FLOAT_BIT];
    next_drive.switch_mode = general[`LDOC_SWITCH_BIT];
  end

  // Registered drive towards the regulator
  // One register stage keeps every output glitch-free; clock enable
  // low holds the last drive unchanged
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_o <= '0;
    end else if (clk_en_i) begin
      drive_o <= next_drive;
    end
  end

endmodule : ldoc_regs

// >>> shared/ldoc_defines.svh
/*
  Offsets, field positions, reset values and codes of the regulator
  control register bank.
  Assumes: included by bare name; the bank sees 16-bit register words.
*/
`ifndef LDOC_DEFINES_SVH
`define LDOC_DEFINES_SVH

// Register addresses (word addressed, 16-bit port)
`define LDOC_ADDR_GENERAL 16'h406E
`define LDOC_ADDR_ON 16'h406F
`define LDOC_ADDR_SLEEP 16'h4070
`define LDOC_ADDR_IRQ_STATUS 16'h4080
`define LDOC_ADDR_IRQ_MASK 16'h4081

// General control fields
`define LDOC_UV_RESP_HI 15
`define LDOC_UV_RESP_LO 14
`define LDOC_HWC_SRC_HI 12
`define LDOC_HWC_SRC_LO 11
`define LDOC_HWC_VCH_BIT 10
`define LDOC_HWC_MODE_HI 9
`define LDOC_HWC_MODE_LO 8
`define LDOC_FLOAT_BIT 7
`define LDOC_SWITCH_BIT 6
`define LDOC_LPV_BIT 0
`define LDOC_GENERAL_MASK 16'hDFC1

// ON and SLEEP control fields
`define LDOC_SLOT_HI 15
`define LDOC_SLOT_LO 13
`define LDOC_MODE_BIT 8
`define LDOC_VCODE_HI 4
`define LDOC_VCODE_LO 0
`define LDOC_STATE_MASK 16'hE11F

// Reset values
`define LDOC_GENERAL_RST 16'h0200
`define LDOC_ON_RST 16'h0000
`define LDOC_SLEEP_RST 16'h0100
`define LDOC_IRQ_MASK_RST 16'h0000

// Interrupt status bits
`define LDOC_IRQ_UV_BIT 0
`define LDOC_IRQ_RSVD_BIT 1
`define LDOC_IRQ_BITS 16'h0003

// Timeslot and slot codes
`define LDOC_SLOT_NONE 3'h0
`define LDOC_SLOT_HWE1 3'h6
`define LDOC_SLOT_HWE2 3'h7
`define LDOC_SLOT_SLEEP_LAST 3'h5

`endif

// >>> shared/ldoc_pkg.sv
/*
  Types shared by the regulator control bank.
  Assumes: nothing beyond the defines header.
*/
package ldoc_pkg;

  // Undervoltage response codes
  typedef enum logic [1:0] {
    LDOC_UV_IGNORE = 2'h0,
    LDOC_UV_SHUT_REG = 2'h1,
    LDOC_UV_SHUT_SYS = 2'h2,
    LDOC_UV_RESERVED = 2'h3
  } ldoc_uv_resp_type;

  // Sequencer phase seen by the bank
  typedef enum logic [1:0] {
    LDOC_PH_OFF = 2'h0,
    LDOC_PH_STARTUP = 2'h1,
    LDOC_PH_ON = 2'h3,
    LDOC_PH_SLEEP = 2'h2
  } ldoc_phase_type;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ldoc_bus_req_type;

  // Drive towards the regulator
  typedef struct packed {
    logic enable;
    logic [4:0] vcode;
    logic low_power;
    logic lp_20ma;
    logic discharge;
    logic switch_mode;
  } ldoc_drive_type;

  // Sequencer status input
  typedef struct packed {
    ldoc_phase_type phase;
    logic [2:0] slot;
  } ldoc_seq_type;

endpackage : ldoc_pkg

// >>> test/ldoc_regs_chk.sv
/* Port checker for the regulator control bank.
   Assumes: bound to ldoc_regs with clock enable held high. */
`timescale 1ns/1ps
`include "ldoc_defines.svh"
module ldoc_regs_chk
  import ldoc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire ldoc_pkg::ldoc_bus_req_type bus_req_i,
  input wire logic [15:0] rdata_o,
  input wire logic undervoltage_i,
  input wire ldoc_pkg::ldoc_drive_type drive_o,
  input wire logic system_reset_req_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Read of one address
  sequence s_rd(a);
    bus_req_i.rd && bus_req_i.addr == a;
  endsequence
  // Recent high fault level or register write, cause of irq moves
  sequence s_uv_near;
    $past(undervoltage_i) || $past(undervoltage_i, 2)
      || $past(undervoltage_i, 3);
  endsequence
  sequence s_wr_near;
    $past(bus_req_i.wr) || $past(bus_req_i.wr, 2)
      || $past(bus_req_i.wr, 3);
  endsequence
  chk_rdata_idle_zero: assert property (
    !bus_req_i.rd |=> rdata_o == 16'h0000) else $error("rdata not idle");
  chk_general_bits: assert property (
    s_rd(`LDOC_ADDR_GENERAL) |=> (rdata_o & 16'h203E) == 16'h0000)
    else $error("general spare bits set");
  chk_on_bits: assert property (
    s_rd(`LDOC_ADDR_ON) |=> (rdata_o & 16'h1EE0) == 16'h0000)
    else $error("on spare bits set");
  chk_sleep_bits: assert property (
    s_rd(`LDOC_ADDR_SLEEP) |=> (rdata_o & 16'h1EE0) == 16'h0000)
    else $error("sleep spare bits set");
  chk_status_bits: assert property (
    s_rd(`LDOC_ADDR_IRQ_STATUS) |=> rdata_o[15:2] == 14'h0000)
    else $error("status spare bits set");
  chk_rst_one_cycle: assert property (
    system_reset_req_o |=> !system_reset_req_o)
    else $error("reset request too long");
  chk_rst_has_cause: assert property (
    system_reset_req_o |-> $past(undervoltage_i) || $past(undervoltage_i, 2))
    else $error("reset request without fault");
  chk_discharge_off: assert property (
    drive_o.discharge |-> !drive_o.enable)
    else $error("discharge while enabled");
  chk_irq_rise_cause: assert property (
    $rose(irq_o) |-> s_uv_near or s_wr_near)
    else $error("irq rose without cause");
  chk_irq_fall_write: assert property (
    $fell(irq_o) |-> s_wr_near) else $error("irq fell without write");
endmodule : ldoc_regs_chk

// >>> test/tb.sv
/* Bench for the regulator control bank: register access, sequencing,
   hardware control and undervoltage handling.
   Assumes: clock enable held high, hardware enable 2 unused. */
`timescale 1ns/1ps
`include "ldoc_defines.svh"
module tb;
  import ldoc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  ldoc_bus_req_type req = '0;
  ldoc_seq_type seq = '0;
  logic hc1 = 1'b0;
  logic hc2 = 1'b0;
  logic uv = 1'b0;
  logic he1 = 1'b0;
  logic [15:0] rdata;
  ldoc_drive_type drv;
  logic sys_rst;
  logic irq;
  int err_count = 0;
  int n_compared = 0;
  // 100 ns period
  always #50 core_clk_i = ~core_clk_i;
  ldoc_regs ldoc_regs_inst (.core_clk_i, .rst_b_i, .clk_en_i(1'b1),
    .bus_req_i(req), .rdata_o(rdata), .seq_i(seq), .hw_control1_i(hc1),
    .hw_control2_i(hc2), .hw_enable1_i(he1), .hw_enable2_i(1'b0),
    .undervoltage_i(uv), .drive_o(drv), .system_reset_req_o(sys_rst),
    .irq_o(irq));
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req.wr <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // Drive is registered: let updates land
  task settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : settle
  task setseq(input ldoc_phase_type p, input logic [2:0] s);
    @(posedge core_clk_i);
    seq <= '{phase: p, slot: s};
    settle();
  endtask : setseq
  // Enable and discharge; voltage code only when enabled
  task dchk(input logic en, input logic dis, input logic [4:0] vc);
    chk({14'h0000, drv.enable, drv.discharge}, {14'h0000, en, dis});
    if (en) begin
      chk({11'h000, drv.vcode}, {11'h000, vc});
    end
  endtask : dchk
  // Bounded wait on reset request (0) or interrupt (1)
  task wait_for(input int which);
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk_i);
      #1;
      if ((which == 0 ? sys_rst : irq) === 1'b1) return;
    end
    err_count++;
    $display("BAD %0t timeout", $time);
    results();
  endtask : wait_for
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(`LDOC_ADDR_GENERAL, 16'h0200);
    rd(`LDOC_ADDR_ON, 16'h0000);
    rd(`LDOC_ADDR_SLEEP, 16'h0100);
    rd(`LDOC_ADDR_IRQ_MASK, 16'h0000);
    rd(16'h4075, 16'h0000);
    wr(`LDOC_ADDR_GENERAL, 16'hFFFF);
    rd(`LDOC_ADDR_GENERAL, 16'hDFC1);
    wr(`LDOC_ADDR_ON, 16'hFFFF);
    rd(`LDOC_ADDR_ON, 16'hE11F);
    wr(`LDOC_ADDR_SLEEP, 16'hFFFF);
    rd(`LDOC_ADDR_SLEEP, 16'hE11F);
    $display("test registers done");
    // Start-up in slot 3, 1.70V code
    wr(`LDOC_ADDR_GENERAL, 16'h0000);
    wr(`LDOC_ADDR_SLEEP, 16'h0000);
    wr(`LDOC_ADDR_ON, 16'h600F);
    setseq(LDOC_PH_STARTUP, 3'h2);
    dchk(1'b0, 1'b1, 5'h00);
    setseq(LDOC_PH_STARTUP, 3'h3);
    dchk(1'b1, 1'b0, 5'h0F);
    setseq(LDOC_PH_ON, 3'h0);
    wr(`LDOC_ADDR_ON, 16'h610E);
    settle();
    dchk(1'b1, 1'b0, 5'h0E);
    chk({15'h0000, drv.low_power}, 16'h0001);
    wr(`LDOC_ADDR_GENERAL, 16'h0041);
    settle();
    chk({15'h0000, drv.lp_20ma}, 16'h0001);
    chk({15'h0000, drv.switch_mode}, 16'h0001);
    $display("test startup done");
    // Sleep code 3 disables in slot 3
    wr(`LDOC_ADDR_SLEEP, 16'h6015);
    setseq(LDOC_PH_SLEEP, 3'h4);
    dchk(1'b1, 1'b0, 5'h0E);
    setseq(LDOC_PH_SLEEP, 3'h3);
    dchk(1'b0, 1'b1, 5'h00);
    // Sleep code 6 moves to sleep settings in slot 3
    setseq(LDOC_PH_STARTUP, 3'h3);
    wr(`LDOC_ADDR_SLEEP, 16'hC11F);
    setseq(LDOC_PH_SLEEP, 3'h4);
    dchk(1'b1, 1'b0, 5'h0E);
    setseq(LDOC_PH_SLEEP, 3'h3);
    dchk(1'b1, 1'b0, 5'h1F);
    $display("test sleep done");
    // Hardware control from input 1 only
    setseq(LDOC_PH_ON, 3'h0);
    wr(`LDOC_ADDR_SLEEP, 16'h0011);
    wr(`LDOC_ADDR_GENERAL, 16'h0D00);
    @(posedge core_clk_i);
    hc2 <= 1'b1;
    settle();
    dchk(1'b1, 1'b0, 5'h0E);
    @(posedge core_clk_i);
    hc1 <= 1'b1;
    settle();
    dchk(1'b0, 1'b1, 5'h00);
    wr(`LDOC_ADDR_GENERAL, 16'h0C00);
    settle();
    dchk(1'b1, 1'b0, 5'h11);
    @(posedge core_clk_i);
    hc1 <= 1'b0;
    hc2 <= 1'b0;
    settle();
    dchk(1'b1, 1'b0, 5'h0E);
    $display("test hardware control done");
    // Enable handed to hardware enable input 1
    wr(`LDOC_ADDR_ON, 16'hC10E);
    settle();
    dchk(1'b0, 1'b1, 5'h00);
    @(posedge core_clk_i);
    he1 <= 1'b1;
    settle();
    dchk(1'b1, 1'b0, 5'h0E);
    wr(`LDOC_ADDR_SLEEP, 16'h6011);
    setseq(LDOC_PH_SLEEP, 3'h3);
    dchk(1'b1, 1'b0, 5'h11);
    setseq(LDOC_PH_ON, 3'h0);
    @(posedge core_clk_i);
    he1 <= 1'b0;
    wr(`LDOC_ADDR_ON, 16'h610E);
    settle();
    dchk(1'b1, 1'b0, 5'h0E);
    $display("test hardware enable done");
    // Undervoltage: system reset, then regulator shut-down
    wr(`LDOC_ADDR_IRQ_MASK, 16'h0001);
    wr(`LDOC_ADDR_GENERAL, 16'h8000);
    @(posedge core_clk_i);
    uv <= 1'b1;
    wait_for(0);
    wait_for(1);
    rd(`LDOC_ADDR_IRQ_STATUS, 16'h0001);
    @(posedge core_clk_i);
    uv <= 1'b0;
    wr(`LDOC_ADDR_IRQ_STATUS, 16'h0001);
    settle();
    chk({15'h0000, irq}, 16'h0000);
    wr(`LDOC_ADDR_GENERAL, 16'h4000);
    @(posedge core_clk_i);
    uv <= 1'b1;
    wait_for(1);
    settle();
    dchk(1'b0, 1'b1, 5'h00);
    @(posedge core_clk_i);
    uv <= 1'b0;
    // Reserved response code is flagged in its own status bit
    wr(`LDOC_ADDR_GENERAL, 16'hC000);
    @(posedge core_clk_i);
    uv <= 1'b1;
    settle();
    rd(`LDOC_ADDR_IRQ_STATUS, 16'h0003);
    chk({15'h0000, sys_rst}, 16'h0000);
    @(posedge core_clk_i);
    uv <= 1'b0;
    $display("test undervoltage done");
    results();
  end
endmodule : tb
bind ldoc_regs ldoc_regs_chk ldoc_regs_chk_inst (.core_clk_i, .rst_b_i,
  .bus_req_i, .rdata_o, .undervoltage_i, .drive_o, .system_reset_req_o,
  .irq_o);
